// ==== rtl/dsoc_pkg.sv ====
package dsoc_pkg;

   // sample word and frame geometry
   localparam int unsigned WORD_W   = 12;
   localparam int unsigned HALF_W   = WORD_W / 2;
   localparam int unsigned CNT_W    = 4;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'hb;
   localparam logic [CNT_W-1:0] CNT_MID  = 4'h5;
   localparam logic [CNT_W-1:0] CNT_RST  = 4'hb;

   // control-port word layout, shifted msb first
   localparam int unsigned CTL_W       = 8;
   localparam logic [2:0]  CTL_LAST    = 3'h7;
   localparam int unsigned CTL_SINGLE  = 7;
   localparam int unsigned CTL_ALIGNED = 6;
   localparam logic [CTL_W-1:0] CTL_RST = 8'h00;

   // loop lock timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned LOCK_TIME_NS  = 4000;
   localparam int unsigned LOCK_CYC      = LOCK_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned LOCK_CNT_W    = 10;

   // one sample pair from the converter core
   typedef struct packed {
      logic [WORD_W-1:0] chan_a;
      logic [WORD_W-1:0] chan_b;
      logic              over_a;
      logic              over_b;
   } dsoc_sample_s;

   // active lane arrangement
   typedef struct packed {
      logic single_lane;
      logic aligned;
   } dsoc_mode_s;

   // serial lane outputs
   typedef struct packed {
      logic chan_a_primary_lane;
      logic chan_b_primary_lane;
      logic chan_a_secondary_lane;
      logic chan_b_secondary_lane;
   } dsoc_lanes_s;

endpackage

// ==== rtl/dsoc_lane_ser.sv ====
`timescale 1ns/1ps
`default_nettype none

// one serial lane: loads a word, shifts msb first, freezes on hold
module dsoc_lane_ser #(
   parameter int unsigned W = 12
) (
   // clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         nrst_i,
   // control
   input  wire logic         load_i,
   input  wire logic         hold_i,
   input  wire logic [W-1:0] word_i,
   // serial bit
   output logic              bit_o
);

   logic [W-1:0] shreg;

   // hold wins so a powered-down lane keeps its last level
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         shreg <= '0;
      end else if (hold_i) begin
         shreg <= shreg;
      end else if (load_i) begin
         shreg <= word_i;
      end else begin
         shreg <= {shreg[W-2:0], 1'b0};
      end
   end

   assign bit_o = shreg[W-1];

endmodule

`default_nettype wire

// ==== rtl/dsoc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module dsoc_top (
   // clocks and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  nrst_i,
   // converter samples
   input  wire dsoc_pkg::dsoc_sample_s sample_i,
   input  wire logic                  sample_valid_i,
   output logic                       sample_ready_o,
   // mode and power pins
   input  wire logic                  lane_config_pin_i,
   input  wire logic                  word_alignment_pin_i,
   input  wire logic                  control_port_enable_i,
   input  wire logic                  power_down_i,
   // loop control pins
   input  wire logic                  loop_reset_i,
   input  wire logic                  clock_disturbed_i,
   output logic                       loop_locked_o,
   // serial link
   output dsoc_pkg::dsoc_lanes_s      lanes_o,
   output logic                       secondary_lane_oe_o,
   output logic                       forwarded_bit_clock_o,
   output logic                       frame_o,
   output logic                       chan_a_overrange_flag_o,
   output logic                       chan_b_overrange_flag_o,
   // control port
   input  wire logic                  ctl_sclk_i,
   input  wire logic                  control_port_chip_select_n_i,
   input  wire logic                  ctl_sdi_i,
   output logic                       ctl_sdo_o,
   output logic                       ctl_sdo_oe_o
);

   // ---------------- pin synchronisers ----------------
   logic [1:0] lane_cfg_ff, align_ff, port_en_ff, pd_ff, lrst_ff, dist_ff, csn_ff;
   logic       lane_cfg_s, align_s, port_en_s, pd_s, lrst_s, dist_s, csn_s;

   // two flops on every asynchronous pin, only the second is read
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         lane_cfg_ff <= '0;
         align_ff    <= '0;
         port_en_ff  <= '0;
         pd_ff       <= '0;
         lrst_ff     <= '0;
         dist_ff     <= '0;
         csn_ff      <= 2'h3;
      end else begin
         lane_cfg_ff <= {lane_cfg_ff[0], lane_config_pin_i};
         align_ff    <= {align_ff[0], word_alignment_pin_i};
         port_en_ff  <= {port_en_ff[0], control_port_enable_i};
         pd_ff       <= {pd_ff[0], power_down_i};
         lrst_ff     <= {lrst_ff[0], loop_reset_i};
         dist_ff     <= {dist_ff[0], clock_disturbed_i};
         csn_ff      <= {csn_ff[0], control_port_chip_select_n_i};
      end
   end

   assign lane_cfg_s = lane_cfg_ff[1];
   assign align_s    = align_ff[1];
   assign port_en_s  = port_en_ff[1];
   assign pd_s       = pd_ff[1];
   assign lrst_s     = lrst_ff[1];
   assign dist_s     = dist_ff[1];
   assign csn_s      = csn_ff[1];

   // ---------------- control port, serial clock domain ----------------
   logic [2:0]                 spi_cnt;
   logic [dsoc_pkg::CTL_W-1:0] spi_shreg;
   logic [dsoc_pkg::CTL_W-1:0] spi_word;
   logic                       spi_word_ok;
   logic [dsoc_pkg::CTL_W-1:0] spi_status;
   logic [dsoc_pkg::CTL_W-1:0] stat_ff1, stat_ff2;

   // bit counter is cleared by the frame's own select, so a stopped
   // serial clock between frames leaves nothing half done
   always_ff @(posedge ctl_sclk_i or posedge control_port_chip_select_n_i) begin
      if (control_port_chip_select_n_i) begin
         spi_cnt <= 3'h0;
      end else begin
         spi_cnt <= spi_cnt + 3'h1;
      end
   end

   // status levels crossing into the serial clock domain
   always_ff @(posedge ctl_sclk_i) begin
      stat_ff1 <= spi_status;
      stat_ff2 <= stat_ff1;
   end

   // shift in from the serial input while selected, msb first
   always_ff @(posedge ctl_sclk_i) begin
      if (!control_port_chip_select_n_i) begin
         if (spi_cnt == 3'h0) begin
            spi_shreg <= {stat_ff2[dsoc_pkg::CTL_W-2:0], ctl_sdi_i};
         end else begin
            spi_shreg <= {spi_shreg[dsoc_pkg::CTL_W-2:0], ctl_sdi_i};
         end
      end
   end

   // completed word, held still after the select goes inactive
   always_ff @(posedge ctl_sclk_i) begin
      if (!control_port_chip_select_n_i && spi_cnt == dsoc_pkg::CTL_LAST) begin
         spi_word    <= {spi_shreg[dsoc_pkg::CTL_W-2:0], ctl_sdi_i};
         spi_word_ok <= 1'b1;
      end else if (!control_port_chip_select_n_i && spi_cnt == 3'h0) begin
         spi_word_ok <= 1'b0;
      end
   end

   // serial output: status msb first, undriven when not selected
   assign ctl_sdo_o    = (spi_cnt == 3'h0) ? stat_ff2[dsoc_pkg::CTL_W-1]
                                           : spi_shreg[dsoc_pkg::CTL_W-1];
   assign ctl_sdo_oe_o = !control_port_chip_select_n_i;

   // ---------------- word handover into the core domain ----------------
   logic [1:0]                 wok_ff;
   logic                       csn_prev;
   logic                       take_word;
   logic [dsoc_pkg::CTL_W-1:0] ctl_reg;

   // the word is stable once select has risen; capture on that edge
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wok_ff   <= '0;
         csn_prev <= 1'b1;
      end else begin
         wok_ff   <= {wok_ff[0], spi_word_ok};
         csn_prev <= csn_s;
      end
   end

   assign take_word = csn_s && !csn_prev && wok_ff[1];

   // port writes are accepted only while the port is enabled
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ctl_reg <= dsoc_pkg::CTL_RST;
      end else if (take_word && port_en_s) begin
         ctl_reg <= spi_word;
      end
   end

   // ---------------- mode selection ----------------
   dsoc_pkg::dsoc_mode_s next_mode, mode;

   // port settings override the pins; pins otherwise
   assign next_mode.single_lane = port_en_s ? ctl_reg[dsoc_pkg::CTL_SINGLE]
                                            : lane_cfg_s;
   assign next_mode.aligned     = port_en_s ? ctl_reg[dsoc_pkg::CTL_ALIGNED]
                                            : align_s;

   // ---------------- frame timing ----------------
   logic [dsoc_pkg::CNT_W-1:0] bit_cnt;
   logic                       run;
   logic                       at_last, at_mid;

   assign run     = !pd_s;
   assign at_last = (bit_cnt == dsoc_pkg::CNT_LAST);
   assign at_mid  = (bit_cnt == dsoc_pkg::CNT_MID);

   // word counter; mode only changes at a word boundary, but lane loads follow next_mode at once
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         bit_cnt <= dsoc_pkg::CNT_RST;
         mode    <= '0;
      end else if (run) begin
         bit_cnt <= at_last ? '0 : bit_cnt + 4'h1;
         if (at_last) begin
            mode <= next_mode;
         end
      end
   end

   // bit clock toggles each cycle: one bit per edge, low in power-down
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         forwarded_bit_clock_o <= 1'b0;
         frame_o               <= 1'b0;
      end else if (run) begin
         forwarded_bit_clock_o <= !forwarded_bit_clock_o;
         // a half word resumed after power-down keeps frame low until the next start
         frame_o               <= at_last || (frame_o && bit_cnt < dsoc_pkg::CNT_MID);
      end else begin
         forwarded_bit_clock_o <= 1'b0;
         frame_o               <= 1'b0;
      end
   end

   // ---------------- sample distribution ----------------
   logic                   dual;
   logic                   take_pt;
   logic                   load_pri, load_sec;
   logic                   sec_from_hold;
   dsoc_pkg::dsoc_sample_s in_word, hold_word, pri_word, sec_word;

   // single-lane takes one sample per word; dual-lane takes two
   assign dual     = !next_mode.single_lane;
   assign take_pt  = run && (at_last || (dual && at_mid));
   assign sample_ready_o = take_pt;
   assign in_word  = sample_valid_i ? sample_i : '0;

   // offset: primary at frame rise, secondary at frame fall
   // aligned: even sample parked at mid word, both load at frame rise
   assign load_pri      = run && at_last;
   assign sec_from_hold = next_mode.aligned;
   assign load_sec      = run && dual && (sec_from_hold ? at_last : at_mid);
   assign pri_word      = (dual && sec_from_hold) ? hold_word : in_word;
   assign sec_word      = in_word;

   // park the even sample for aligned dual-lane words
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         hold_word <= '0;
      end else if (run && dual && at_mid) begin
         hold_word <= in_word;
      end
   end

   // lanes: four copies of one shifter, frozen together in power-down
   dsoc_lane_ser #(.W(dsoc_pkg::WORD_W)) u_pri_a (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .load_i     (load_pri),
      .hold_i     (pd_s),
      .word_i     (pri_word.chan_a),
      .bit_o      (lanes_o.chan_a_primary_lane)
   );
   dsoc_lane_ser #(.W(dsoc_pkg::WORD_W)) u_pri_b (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .load_i     (load_pri),
      .hold_i     (pd_s),
      .word_i     (pri_word.chan_b),
      .bit_o      (lanes_o.chan_b_primary_lane)
   );
   dsoc_lane_ser #(.W(dsoc_pkg::WORD_W)) u_sec_a (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .load_i     (load_sec),
      .hold_i     (pd_s),
      .word_i     (sec_word.chan_a),
      .bit_o      (lanes_o.chan_a_secondary_lane)
   );
   dsoc_lane_ser #(.W(dsoc_pkg::WORD_W)) u_sec_b (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .load_i     (load_sec),
      .hold_i     (pd_s),
      .word_i     (sec_word.chan_b),
      .bit_o      (lanes_o.chan_b_secondary_lane)
   );

   // secondary lanes only driven in dual-lane mode
   assign secondary_lane_oe_o = !mode.single_lane;

   // overrange follows each primary word and each offset secondary word onto the lanes
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         chan_a_overrange_flag_o <= 1'b0;
         chan_b_overrange_flag_o <= 1'b0;
      end else if (load_pri) begin
         chan_a_overrange_flag_o <= pri_word.over_a;
         chan_b_overrange_flag_o <= pri_word.over_b;
      end else if (load_sec) begin
         chan_a_overrange_flag_o <= sec_word.over_a;
         chan_b_overrange_flag_o <= sec_word.over_b;
      end
   end

   // ---------------- loop lock tracking ----------------
   logic [dsoc_pkg::LOCK_CNT_W-1:0] lock_cnt;
   logic                            lost;

   // lock waits a settle time after reset or a loop reset pulse;
   // a disturbed clock drops lock until the host pulses loop reset
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         lock_cnt      <= '0;
         lost          <= 1'b0;
         loop_locked_o <= 1'b0;
      end else if (dist_s) begin
         lost          <= 1'b1;
         loop_locked_o <= 1'b0;
      end else if (lrst_s) begin
         lost          <= 1'b0;
         lock_cnt      <= '0;
         loop_locked_o <= 1'b0;
      end else if (!lost && !loop_locked_o) begin
         if (lock_cnt == dsoc_pkg::LOCK_CNT_W'(dsoc_pkg::LOCK_CYC - 1)) begin
            loop_locked_o <= 1'b1;
         end else begin
            lock_cnt <= lock_cnt + 10'h001;
         end
      end
   end

   // status byte returned on the serial output
   assign spi_status = {mode.single_lane, mode.aligned, loop_locked_o, pd_s, 4'h0};

   // ---------------- checks ----------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   a_single_sec_off: assert property (mode.single_lane |-> !secondary_lane_oe_o)
      else $error("secondary lane driven in single-lane mode");
   a_pd_lane_freeze: assert property (pd_s && $past(pd_s) |=> $stable(lanes_o))
      else $error("lane moved during power-down");
   a_bit_clk_edge: assert property (run && $past(run) && $past(nrst_i) |->
      forwarded_bit_clock_o != $past(forwarded_bit_clock_o))
      else $error("bit clock missed an edge");
   a_frame_rise_word: assert property ($rose(frame_o) |-> $past(load_pri, 1))
      else $error("frame rose without a primary word start");
   // power-down stretches the word, so it abandons the check
   a_offset_sec_mid: assert property (disable iff (!nrst_i || pd_s)
      load_sec && !sec_from_hold |-> at_mid ##6 load_pri)
      else $error("offset secondary word not half a word from primary");
   a_single_no_sec: assert property (next_mode.single_lane |->
      !load_sec && !(run && at_mid && sample_ready_o))
      else $error("single-lane mode took a secondary sample");
   a_port_over_pins: assert property (port_en_s |->
      next_mode.single_lane == ctl_reg[dsoc_pkg::CTL_SINGLE])
      else $error("mode pin used while control port enabled");
   a_pins_direct: assert property (!port_en_s |->
      next_mode.single_lane == lane_cfg_s && next_mode.aligned == align_s)
      else $error("control port used while disabled");
   a_lock_drop: assert property (dist_s |=> !loop_locked_o [*2])
      else $error("lock held through clock disturbance");
   a_lock_settle: assert property ($rose(lrst_s) && !dist_s |=>
      !loop_locked_o ##1 !loop_locked_o [*8])
      else $error("lock rose too soon after loop reset");
   a_ovr_follow: assert property (load_pri |=>
      chan_a_overrange_flag_o == $past(pri_word.over_a))
      else $error("overrange not in step with its word");

   c_single_word: cover property (mode.single_lane && load_pri && sample_valid_i);
   c_dual_aligned: cover property (!mode.single_lane && mode.aligned && load_sec);
   c_dual_offset: cover property (!mode.single_lane && !mode.aligned && load_sec);
   c_power_down: cover property ($rose(pd_s) ##[1:50] $fell(pd_s));
   c_relock: cover property (lost ##[1:1000] $rose(loop_locked_o));

endmodule

`default_nettype wire

// ==== verif/dsoc_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// capture receiver: rebuilds lane words from the frame strobe edges
module dsoc_rx_model (
   // clock and receiver setting
   input  wire logic                  core_clk_i,
   input  wire logic                  aligned_i,
   // serial link
   input  wire dsoc_pkg::dsoc_lanes_s lanes_i,
   input  wire logic                  bit_clk_i,
   input  wire logic                  frame_i,
   input  wire logic                  over_a_i,
   input  wire logic                  over_b_i,
   // rebuilt words {chan a, chan b}, flags {b, a} and counts
   output logic [23:0]                prim_o,
   output logic [23:0]                sec_o,
   output logic [1:0]                 flag_o,
   output int                         prim_cnt_o,
   output int                         clk_err_o
);
   logic [23:0] p_sh;
   logic [23:0] s_sh;
   int          p_left;
   int          s_left;
   logic        fr_q;
   logic        bc_q;

   // receiver starts idle
   initial begin
      p_left = 0;
      s_left = 0;
      fr_q = 1'b0;
      bc_q = 1'b0;
      prim_cnt_o = 0;
      clk_err_o = 0;
   end

   // sample mid-cell: bit clock edges sit on cell boundaries, so edge sampling would race
   always @(negedge core_clk_i) begin
      if (frame_i && !fr_q) begin
         p_left = 12;
      end
      if (aligned_i ? (frame_i && !fr_q) : (!frame_i && fr_q)) begin
         s_left = 12;
      end
      if (p_left > 0) begin
         p_sh = {p_sh[22:12], lanes_i.chan_a_primary_lane,
                 p_sh[10:0], lanes_i.chan_b_primary_lane};
         p_left--;
         if (p_left == 6) flag_o = {over_b_i, over_a_i};
         if (p_left == 0) prim_o = p_sh;
         if (p_left == 0) prim_cnt_o++;
         if (p_left > 0 && p_left < 11 && bit_clk_i === bc_q) clk_err_o++;
      end
      if (s_left > 0) begin
         s_sh = {s_sh[22:12], lanes_i.chan_a_secondary_lane,
                 s_sh[10:0], lanes_i.chan_b_secondary_lane};
         s_left--;
         if (s_left == 0) sec_o = s_sh;
      end
      fr_q = frame_i;
      bc_q = bit_clk_i;
   end
endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int LOCK = dsoc_pkg::LOCK_CYC;

   // design inputs
   logic core_clk_i;
   logic nrst_i;
   dsoc_pkg::dsoc_sample_s sample_i;
   logic sample_valid_i;
   logic lane_config_pin_i;
   logic word_alignment_pin_i;
   logic control_port_enable_i;
   logic power_down_i;
   logic loop_reset_i;
   logic clock_disturbed_i;
   logic ctl_sclk_i;
   logic control_port_chip_select_n_i;
   logic ctl_sdi_i;
   // design outputs
   logic sample_ready_o;
   logic loop_locked_o;
   dsoc_pkg::dsoc_lanes_s lanes_o;
   logic secondary_lane_oe_o;
   logic forwarded_bit_clock_o;
   logic frame_o;
   logic chan_a_overrange_flag_o;
   logic chan_b_overrange_flag_o;
   logic ctl_sdo_o;
   logic ctl_sdo_oe_o;
   // receiver side and bookkeeping
   logic [23:0] rx_prim;
   logic [23:0] rx_sec;
   logic [1:0] rx_flag;
   logic rx_aligned;
   int rx_cnt;
   int clk_err;
   logic [7:0] seq;
   logic took;
   int errors;
   int checked;

   dsoc_top uut (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .sample_i(sample_i),
      .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
      .lane_config_pin_i(lane_config_pin_i), .word_alignment_pin_i(word_alignment_pin_i),
      .control_port_enable_i(control_port_enable_i), .power_down_i(power_down_i),
      .loop_reset_i(loop_reset_i), .clock_disturbed_i(clock_disturbed_i),
      .loop_locked_o(loop_locked_o), .lanes_o(lanes_o),
      .secondary_lane_oe_o(secondary_lane_oe_o), .forwarded_bit_clock_o(forwarded_bit_clock_o),
      .frame_o(frame_o), .chan_a_overrange_flag_o(chan_a_overrange_flag_o),
      .chan_b_overrange_flag_o(chan_b_overrange_flag_o), .ctl_sclk_i(ctl_sclk_i),
      .control_port_chip_select_n_i(control_port_chip_select_n_i), .ctl_sdi_i(ctl_sdi_i),
      .ctl_sdo_o(ctl_sdo_o), .ctl_sdo_oe_o(ctl_sdo_oe_o)
   );

   dsoc_rx_model rx (
      .core_clk_i(core_clk_i), .aligned_i(rx_aligned), .lanes_i(lanes_o),
      .bit_clk_i(forwarded_bit_clock_o), .frame_i(frame_o), .over_a_i(chan_a_overrange_flag_o),
      .over_b_i(chan_b_overrange_flag_o),
      .prim_o(rx_prim), .sec_o(rx_sec), .flag_o(rx_flag), .prim_cnt_o(rx_cnt),
      .clk_err_o(clk_err)
   );

   // core clock, 8 ns
   always #4 core_clk_i = ~core_clk_i;

   // sample source: sequence number in both channels lets the receiver tell samples apart
   assign sample_i = {4'h0, seq, seq, 4'h5, seq[0], seq[1]};
   always @(posedge core_clk_i) took <= nrst_i & sample_ready_o;
   always @(negedge core_clk_i) if (took) seq <= seq + 8'h01;

   task automatic test_done();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask

   // bounded wait for n more received primary words
   task automatic wait_prim(input int n);
      int k;
      int c0;
      c0 = rx_cnt;
      for (k = 0; k < 400 * n && rx_cnt < c0 + n; k++) @(negedge core_clk_i);
      if (rx_cnt < c0 + n) begin
         cmp(0, 1, "no word on primary lane");
         test_done();
      end
   endtask

   // skip words in flight across a mode change, then judge n words
   task automatic chk_stream(input logic dual, input logic al, input int n);
      logic [7:0] last;
      int i;
      int e0;
      rx_aligned = al;
      wait_prim(3);
      last = rx_prim[19:12];
      e0 = clk_err;
      for (i = 0; i < n; i++) begin
         wait_prim(1);
         cmp(rx_prim, {4'h0, rx_prim[19:12], rx_prim[19:12], 4'h5}, "primary word");
         cmp(8'(rx_prim[19:12] - last), dual ? 2 : 1, "primary sample step");
         last = rx_prim[19:12];
         if (dual) begin
            cmp(rx_sec, {4'h0, rx_sec[19:12], rx_sec[19:12], 4'h5}, "secondary word");
            cmp(al ? 8'(rx_sec[19:12] - last) : 8'(last - rx_sec[19:12]), 1, "lane offset");
         end else begin
            cmp(rx_flag, rx_prim[13:12], "overrange flags");
         end
      end
      cmp(secondary_lane_oe_o, dual, "secondary drive");
      cmp(clk_err - e0, 0, "bit clock edges");
   endtask

   // one control-port word, msb first, status read before each rising sclk
   task automatic ctl_xfer(input logic [7:0] w, output logic [7:0] r);
      int i;
      control_port_chip_select_n_i = 1'b0;
      for (i = 7; i >= 0; i--) begin
         ctl_sdi_i = w[i];
         #15;
         r[i] = ctl_sdo_o;
         cmp(ctl_sdo_oe_o, 1, "sdo driven while selected");
         ctl_sclk_i = 1'b1;
         #15;
         ctl_sclk_i = 1'b0;
      end
      #15;
      control_port_chip_select_n_i = 1'b1;
      #15;
      cmp(ctl_sdo_oe_o, 0, "sdo released");
   endtask

   task automatic wait_lock(input int lo, input int hi, input string msg);
      int n;
      n = 0;
      while (loop_locked_o !== 1'b1 && n < 2000) begin
         @(negedge core_clk_i);
         n++;
      end
      cmp(n >= lo && n <= hi, 1, msg);
      if (n >= 2000) test_done();
   endtask

   task automatic t_lock();
      // first word of sample 0 starts on the first edge after release
      cmp({lanes_o, frame_o, loop_locked_o}, 6'h02, "outputs after reset");
      wait_lock(LOCK - 4, LOCK + 8, "lock time");
      clock_disturbed_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      clock_disturbed_i = 1'b0;
      repeat (6) @(negedge core_clk_i);
      cmp(loop_locked_o, 0, "lock lost");
      repeat (40) @(negedge core_clk_i);
      cmp(loop_locked_o, 0, "lock stays lost");
      loop_reset_i = 1'b1;
      repeat (125) @(negedge core_clk_i);
      loop_reset_i = 1'b0;
      wait_lock(LOCK - 8, LOCK + 8, "relock time");
      $display("done: loop lock");
   endtask

   task automatic t_pins();
      lane_config_pin_i = 1'b1;
      chk_stream(0, 0, 6);
      lane_config_pin_i = 1'b0;
      chk_stream(1, 0, 6);
      word_alignment_pin_i = 1'b1;
      chk_stream(1, 1, 6);
      word_alignment_pin_i = 1'b0;
      $display("done: lane modes");
   endtask

   task automatic t_pd();
      dsoc_pkg::dsoc_lanes_s held;
      int i;
      power_down_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      held = lanes_o;
      for (i = 0; i < 24; i++) begin
         @(negedge core_clk_i);
         cmp(lanes_o, held, "lanes frozen");
         cmp({forwarded_bit_clock_o, frame_o, sample_ready_o}, 0, "link quiet");
      end
      power_down_i = 1'b0;
      chk_stream(1, 0, 3);
      $display("done: power down");
   endtask

   task automatic t_ctl();
      logic [7:0] r;
      control_port_enable_i = 1'b1;
      ctl_xfer(8'h80, r);
      repeat (40) @(negedge core_clk_i);
      ctl_xfer(8'h80, r);
      // status is snapshotted on the previous frame's serial clock edges
      ctl_xfer(8'h80, r);
      cmp(r, 8'ha0, "status byte");
      chk_stream(0, 0, 3);
      ctl_xfer(8'h40, r);
      chk_stream(1, 1, 3);
      control_port_enable_i = 1'b0;
      lane_config_pin_i = 1'b1;
      chk_stream(0, 0, 3);
      $display("done: control port");
   endtask

   // main sequence
   initial begin
      errors = 0;
      checked = 0;
      core_clk_i = 1'b0;
      nrst_i = 1'b0;
      seq = 8'h00;
      took = 1'b0;
      sample_valid_i = 1'b1;
      lane_config_pin_i = 1'b0;
      word_alignment_pin_i = 1'b0;
      control_port_enable_i = 1'b0;
      power_down_i = 1'b0;
      loop_reset_i = 1'b0;
      clock_disturbed_i = 1'b0;
      ctl_sclk_i = 1'b0;
      control_port_chip_select_n_i = 1'b1;
      ctl_sdi_i = 1'b0;
      rx_aligned = 1'b0;
      repeat (12) @(negedge core_clk_i);
      nrst_i = 1'b1;
      @(negedge core_clk_i);
      t_lock();
      t_pins();
      t_pd();
      t_ctl();
      test_done();
   end
endmodule

`default_nettype wire
